// ---- verilog/ttc_defs.vh ----
/*
 Constants for the tape transport controller: register map, field
 positions, state codes and timing counts.
 Assumes a 100 MHz clock and an AXI4-Lite register bus.
*/
`ifndef TTC_DEFS_VH
`define TTC_DEFS_VH

// Register byte addresses
`define TTC_ADDR_BUTTONS 8'h00
`define TTC_ADDR_EVENTS 8'h04
`define TTC_ADDR_CONFIG 8'h08
`define TTC_ADDR_STATUS 8'h0c
`define TTC_ADDR_LEDS 8'h10

// Button bits in the buttons register (levels, held)
`define TTC_B_EJECT 0
`define TTC_B_REW 1
`define TTC_B_FFWD 2
`define TTC_B_PLAY 3
`define TTC_B_REC 4
`define TTC_B_STOP 5
`define TTC_B_CLKSEL 6
`define TTC_B_SETLOC 7
`define TTC_B_ARM_LO 8
`define TTC_B_ARM_HI 15
`define TTC_ARM4 11

// Event bits written by the mechanism side
`define TTC_E_AT_START 0
`define TTC_E_AT_END 1
`define TTC_E_LOC_DONE 2
`define TTC_E_LOC_GO 3
`define TTC_E_INSERT 4
`define TTC_E_FMT_OK 5
`define TTC_E_RATE_VALID 6
`define TTC_E_RATE_441 7
`define TTC_E_FORMATTING 8
`define TTC_E_SLAVE 9
`define TTC_E_NO_TAPE 10

// Primary transport states
`define TTC_S_STOP 4'h0
`define TTC_S_PLAY 4'h1
`define TTC_S_REC 4'h2
`define TTC_S_REW 4'h3
`define TTC_S_FFWD 4'h4
`define TTC_S_REVIEW 4'h5
`define TTC_S_CUE 4'h6
`define TTC_S_LOCATE 4'h7
`define TTC_S_EJECT 4'h8

// Clock settings
`define TTC_CLK_INT48 2'h0
`define TTC_CLK_INT441 2'h1
`define TTC_CLK_DIG48 2'h2
`define TTC_CLK_DIG441 2'h3

// Speeds in multiples of play speed
`define TTC_SPEED_PLAY 6'h01
`define TTC_SPEED_SEARCH 6'h03
`define TTC_SPEED_WIND 6'h28
`define TTC_SPEED_WIND_FAST 6'h2c

// Crossfade lengths in ms, at 48k then 44.1k
`define TTC_XF0_48 6'h0b
`define TTC_XF1_48 6'h15
`define TTC_XF2_48 6'h20
`define TTC_XF3_48 6'h2b
`define TTC_XF0_441 6'h0c
`define TTC_XF1_441 6'h17
`define TTC_XF2_441 6'h23
`define TTC_XF3_441 6'h2e

// Timing
`define TTC_CLK_MHZ 100
`define TTC_MS_CYCLES (`TTC_CLK_MHZ * 1000)
`define TTC_BLINK_MS 250
`define TTC_MSG_MS 1500

// AXI responses
`define TTC_RESP_OKAY 2'h0
`define TTC_RESP_SLVERR 2'h2

`endif

// ---- verilog/ttc_top.v ----
/*
 Tape transport controller: front-panel decode, transport state,
 threading, punch in and out, clock and crossfade selection, display
 mode and indicator drive, with an AXI4-Lite register slave.
 Assumes buttons arrive as held levels written by software, and the
 mechanism reports its events through the events register.
*/
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ttc_defs.vh"

module ttc_top #(
   parameter BLINK_CYCLES = `TTC_BLINK_MS * `TTC_MS_CYCLES,
   parameter MSG_CYCLES = `TTC_MSG_MS * `TTC_MS_CYCLES,
   parameter MS_CYCLES = `TTC_MS_CYCLES
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   output reg slave_eject_reg,
   output reg eject_motor_reg,
   output reg threaded_reg,
   output reg [5:0] speed_reg,
   output reg reverse_reg,
   output reg audio_atten_reg,
   output reg [7:0] track_recording_reg,
   output reg [5:0] crossfade_ms_reg,
   output reg crossfade_start_reg,
   output reg [15:0] led_reg
);

   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------
   reg [15:0] buttons_reg;
   reg [15:0] buttons_prev_reg;
   reg [10:0] events_reg;
   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg rec_mode_reg;
   reg threaded_st_reg;
   reg defer_play_reg;
   reg no_format_reg;
   reg [7:0] armed_reg;
   reg [1:0] clk_sel_reg;
   reg tape_rate_441_reg;
   reg [1:0] xfade_reg;
   reg frames_mode_reg;
   reg [1:0] msg_reg;
   reg [31:0] msg_cnt_reg;
   reg [31:0] blink_cnt_reg;
   reg blink_reg;
   reg [31:0] xf_cnt_reg;
   reg [5:0] xf_left_reg;
   reg [7:0] wr_addr_reg;
   reg [31:0] wr_data_reg;
   reg aw_have_reg;
   reg w_have_reg;
   reg insert_prev_reg;

   wire [15:0] press = buttons_reg & ~buttons_prev_reg;
   wire [7:0] arm_press = press[`TTC_B_ARM_HI:`TTC_B_ARM_LO];
   wire held_play = buttons_reg[`TTC_B_PLAY];
   wire held_rec = buttons_reg[`TTC_B_REC];
   wire held_setloc = buttons_reg[`TTC_B_SETLOC];
   wire recording = (state_reg == `TTC_S_REC);
   wire stopped = (state_reg == `TTC_S_STOP);

   // Crossfade length for a setting at the current sample clock
   function [5:0] xf_len;
      input [1:0] sel;
      input low_rate;
      begin
         case ({low_rate, sel})
            3'h0: xf_len = `TTC_XF0_48;
            3'h1: xf_len = `TTC_XF1_48;
            3'h2: xf_len = `TTC_XF2_48;
            3'h3: xf_len = `TTC_XF3_48;
            3'h4: xf_len = `TTC_XF0_441;
            3'h5: xf_len = `TTC_XF1_441;
            3'h6: xf_len = `TTC_XF2_441;
            default: xf_len = `TTC_XF3_441;
         endcase
      end
   endfunction

   wire low_rate = clk_sel_reg[0];

   // -------------------------------------------------------------
   // AXI4-Lite write channel
   // -------------------------------------------------------------
   // Address and data are latched independently, answer follows both
   wire wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TTC_RESP_OKAY;
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         wr_data_reg <= 32'h0000_0000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr_reg <= s_axi_awaddr;
            aw_have_reg <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data_reg <= s_axi_wdata;
            w_have_reg <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            if (wr_addr_reg == `TTC_ADDR_BUTTONS ||
                wr_addr_reg == `TTC_ADDR_EVENTS)
               s_axi_bresp <= `TTC_RESP_OKAY;
            else
               s_axi_bresp <= `TTC_RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write strobes are ignored on purpose: both registers are 16 bits
   // or less and software always writes them whole.
   always @(posedge aclk) begin
      if (!aresetn) begin
         buttons_reg <= 16'h0000;
         events_reg <= 11'h000;
      end else if (wr_go && wr_addr_reg == `TTC_ADDR_BUTTONS) begin
         buttons_reg <= wr_data_reg[15:0];
      end else if (wr_go && wr_addr_reg == `TTC_ADDR_EVENTS) begin
         events_reg <= wr_data_reg[10:0];
      end
   end

   // -------------------------------------------------------------
   // AXI4-Lite read channel
   // -------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TTC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `TTC_RESP_OKAY;
         case (s_axi_araddr)
            `TTC_ADDR_BUTTONS: s_axi_rdata <= {16'h0000, buttons_reg};
            `TTC_ADDR_EVENTS: s_axi_rdata <= {21'h000000, events_reg};
            `TTC_ADDR_CONFIG: s_axi_rdata <= {24'h000000, msg_reg,
               frames_mode_reg, tape_rate_441_reg, xfade_reg, clk_sel_reg};
            `TTC_ADDR_STATUS: s_axi_rdata <= {12'h000, armed_reg,
               4'h0, no_format_reg, defer_play_reg, threaded_st_reg,
               rec_mode_reg, state_reg};
            `TTC_ADDR_LEDS: s_axi_rdata <= {16'h0000, led_reg};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `TTC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // Transport state decision
   // -------------------------------------------------------------
   // Priority: eject, stop, wind keys, record combos, play.
   always @* begin
      state_next = state_reg;
      case (state_reg)
         `TTC_S_STOP, `TTC_S_PLAY, `TTC_S_REC, `TTC_S_REW, `TTC_S_FFWD,
         `TTC_S_REVIEW, `TTC_S_CUE, `TTC_S_LOCATE: begin
            if (press[`TTC_B_EJECT] && !recording &&
                !events_reg[`TTC_E_FORMATTING])
               state_next = `TTC_S_EJECT;
            else if (press[`TTC_B_STOP])
               state_next = `TTC_S_STOP;
            else if (recording && !events_reg[`TTC_E_FMT_OK])
               state_next = `TTC_S_STOP;
            else if (press[`TTC_B_REW])
               state_next = held_play ? `TTC_S_REVIEW : `TTC_S_REW;
            else if (press[`TTC_B_FFWD])
               state_next = held_play ? `TTC_S_CUE : `TTC_S_FFWD;
            else if ((press[`TTC_B_REC] && held_play) ||
                     (press[`TTC_B_PLAY] && held_rec))
               state_next = recording ? `TTC_S_PLAY : `TTC_S_REC;
            else if (press[`TTC_B_PLAY] && state_reg != `TTC_S_LOCATE)
               state_next = `TTC_S_PLAY;
            else if (state_reg == `TTC_S_REC && rec_mode_reg &&
                     armed_reg == 8'h00 && |track_recording_reg)
               state_next = `TTC_S_PLAY;
            else if (events_reg[`TTC_E_LOC_GO] && !recording)
               state_next = `TTC_S_LOCATE;
            else if (state_reg == `TTC_S_LOCATE &&
                     events_reg[`TTC_E_LOC_DONE])
               state_next = (defer_play_reg || press[`TTC_B_PLAY]) ?
                            `TTC_S_PLAY : `TTC_S_STOP;
            else if ((state_reg == `TTC_S_REW ||
                      state_reg == `TTC_S_REVIEW) &&
                     events_reg[`TTC_E_AT_START])
               state_next = `TTC_S_STOP;
            else if ((state_reg == `TTC_S_FFWD ||
                      state_reg == `TTC_S_CUE) &&
                     events_reg[`TTC_E_AT_END])
               state_next = `TTC_S_STOP;
         end
         `TTC_S_EJECT: begin
            if (events_reg[`TTC_E_NO_TAPE])
               state_next = `TTC_S_STOP;
         end
         default: state_next = `TTC_S_STOP;
      endcase
   end

   // -------------------------------------------------------------
   // Transport state, threading, arming and modes
   // -------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= `TTC_S_STOP;
         buttons_prev_reg <= 16'h0000;
         rec_mode_reg <= 1'b0;
         threaded_st_reg <= 1'b1;
         defer_play_reg <= 1'b0;
         no_format_reg <= 1'b0;
         armed_reg <= 8'h00;
         clk_sel_reg <= `TTC_CLK_INT48;
         tape_rate_441_reg <= 1'b0;
         xfade_reg <= 2'h0;
         frames_mode_reg <= 1'b0;
         msg_reg <= 2'h0;
         msg_cnt_reg <= 32'h0000_0000;
         insert_prev_reg <= 1'b0;
      end else begin
         buttons_prev_reg <= buttons_reg;
         insert_prev_reg <= events_reg[`TTC_E_INSERT];
         state_reg <= state_next;
         rec_mode_reg <= (state_next == `TTC_S_REC);
         // Stop press while already stopped toggles threading
         if (stopped && state_next == `TTC_S_STOP && press[`TTC_B_STOP])
            threaded_st_reg <= ~threaded_st_reg;
         else if (state_next == `TTC_S_PLAY || state_next == `TTC_S_REC ||
                  state_next == `TTC_S_REVIEW || state_next == `TTC_S_CUE)
            threaded_st_reg <= 1'b1;
         // Deferred play only while locating
         if (state_reg == `TTC_S_LOCATE && press[`TTC_B_PLAY])
            defer_play_reg <= 1'b1;
         else if (state_next != `TTC_S_LOCATE)
            defer_play_reg <= 1'b0;
         if (state_next == `TTC_S_PLAY && !events_reg[`TTC_E_FMT_OK])
            no_format_reg <= 1'b1;
         else if (state_next != `TTC_S_PLAY || events_reg[`TTC_E_FMT_OK])
            no_format_reg <= 1'b0;
         // Arm toggles, except arm four under set-locate
         if (held_setloc)
            armed_reg <= armed_reg ^ (arm_press & 8'hf7);
         else
            armed_reg <= armed_reg ^ arm_press;
         // Act once per insertion, so clock select works with a tape in
         if (events_reg[`TTC_E_INSERT] && !insert_prev_reg) begin
            tape_rate_441_reg <= events_reg[`TTC_E_RATE_VALID] &
                                 events_reg[`TTC_E_RATE_441];
            clk_sel_reg <= (events_reg[`TTC_E_RATE_VALID] &&
                            events_reg[`TTC_E_RATE_441]) ?
                           `TTC_CLK_INT441 : `TTC_CLK_INT48;
         end else if (press[`TTC_B_CLKSEL]) begin
            clk_sel_reg <= clk_sel_reg + 2'h1;
         end
         if (held_setloc && press[`TTC_B_REC])
            xfade_reg <= xfade_reg + 2'h1;
         // Display mode message held for a short while
         if (held_setloc && press[`TTC_ARM4]) begin
            frames_mode_reg <= ~frames_mode_reg;
            msg_reg <= frames_mode_reg ? 2'h2 : 2'h1;
            msg_cnt_reg <= MSG_CYCLES - 1;
         end else if (msg_cnt_reg != 32'h0000_0000) begin
            msg_cnt_reg <= msg_cnt_reg - 32'h0000_0001;
         end else begin
            msg_reg <= 2'h0;
         end
      end
   end

   // -------------------------------------------------------------
   // Common blink timebase
   // -------------------------------------------------------------
   // One counter for every flashing indicator keeps them in phase
   always @(posedge aclk) begin
      if (!aresetn) begin
         blink_cnt_reg <= 32'h0000_0000;
         blink_reg <= 1'b0;
      end else if (blink_cnt_reg == BLINK_CYCLES - 1) begin
         blink_cnt_reg <= 32'h0000_0000;
         blink_reg <= ~blink_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
      end
   end

   // -------------------------------------------------------------
   // Mechanism commands and crossfade timer
   // -------------------------------------------------------------
   wire winding = (state_reg == `TTC_S_REW || state_reg == `TTC_S_FFWD);
   wire searching = (state_reg == `TTC_S_REVIEW ||
                     state_reg == `TTC_S_CUE);
   wire [7:0] rec_next = rec_mode_reg ? armed_reg : 8'h00;
   always @(posedge aclk) begin
      if (!aresetn) begin
         slave_eject_reg <= 1'b0;
         eject_motor_reg <= 1'b0;
         threaded_reg <= 1'b1;
         speed_reg <= 6'h00;
         reverse_reg <= 1'b0;
         audio_atten_reg <= 1'b0;
         track_recording_reg <= 8'h00;
         crossfade_ms_reg <= `TTC_XF0_48;
         crossfade_start_reg <= 1'b0;
         xf_cnt_reg <= 32'h0000_0000;
         xf_left_reg <= 6'h00;
      end else begin
         // Eject only once motion has been commanded to zero
         eject_motor_reg <= (state_reg == `TTC_S_EJECT) &&
                            (speed_reg == 6'h00);
         slave_eject_reg <= (state_reg == `TTC_S_EJECT) &&
                            !events_reg[`TTC_E_SLAVE];
         threaded_reg <= threaded_st_reg;
         reverse_reg <= (state_reg == `TTC_S_REW ||
                         state_reg == `TTC_S_REVIEW);
         audio_atten_reg <= searching;
         if (winding)
            speed_reg <= threaded_st_reg ? `TTC_SPEED_WIND
                                         : `TTC_SPEED_WIND_FAST;
         else if (searching)
            speed_reg <= `TTC_SPEED_SEARCH;
         else if (state_reg == `TTC_S_PLAY || recording ||
                  state_reg == `TTC_S_LOCATE)
            speed_reg <= `TTC_SPEED_PLAY;
         else
            speed_reg <= 6'h00;
         // Arming while in record mode starts that track at once
         track_recording_reg <= rec_next;
         crossfade_ms_reg <= xf_len(xfade_reg, low_rate);
         crossfade_start_reg <= 1'b0;
         if (rec_next != track_recording_reg) begin
            crossfade_start_reg <= 1'b1;
            xf_left_reg <= xf_len(xfade_reg, low_rate);
            xf_cnt_reg <= 32'h0000_0000;
         end else if (xf_left_reg != 6'h00) begin
            if (xf_cnt_reg == MS_CYCLES - 1) begin
               xf_cnt_reg <= 32'h0000_0000;
               xf_left_reg <= xf_left_reg - 6'h01;
            end else begin
               xf_cnt_reg <= xf_cnt_reg + 32'h0000_0001;
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Indicator decode
   // -------------------------------------------------------------
   // led bits: 0 stop 1 play 2 rec 3 rew 4 ffwd 5 eject 6 format
   // 7 rate mismatch 8..15 track record indicators
   wire rate_mismatch = (clk_sel_reg[0] != tape_rate_441_reg);
   always @(posedge aclk) begin
      if (!aresetn) begin
         led_reg <= 16'h0001;
      end else begin
         led_reg[0] <= stopped && (threaded_st_reg || blink_reg);
         led_reg[1] <= (state_reg == `TTC_S_PLAY) || recording || searching ||
                       (defer_play_reg && blink_reg);
         led_reg[2] <= recording && ((armed_reg != 8'h00) || blink_reg);
         led_reg[3] <= (state_reg == `TTC_S_REW) ||
                       (state_reg == `TTC_S_REVIEW && blink_reg);
         led_reg[4] <= (state_reg == `TTC_S_FFWD) ||
                       (state_reg == `TTC_S_CUE && blink_reg);
         led_reg[5] <= (state_reg == `TTC_S_EJECT);
         led_reg[6] <= no_format_reg && blink_reg;
         led_reg[7] <= rate_mismatch && blink_reg;
         led_reg[15:8] <= armed_reg & ((rec_mode_reg) ? 8'hff :
                          {8{blink_reg}});
      end
   end

endmodule // ttc_top
`default_nettype wire

// ---- tb/ttc_top_asserts.sv ----
/*
 Checker for the transport controller outputs.
 Assumes it is bound to ttc_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ttc_defs.vh"
module ttc_top_asserts (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic eject_motor_reg,
   input wire logic threaded_reg,
   input wire logic [5:0] speed_reg,
   input wire logic audio_atten_reg,
   input wire logic [7:0] track_recording_reg,
   input wire logic [5:0] crossfade_ms_reg,
   input wire logic crossfade_start_reg,
   input wire logic [15:0] led_reg
);
   // ---------------------------------
   // Output relations
   // ---------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_EJ_STILL: assert property (
      eject_motor_reg |-> speed_reg == 6'h00) else $error("eject moving");
   AST_FAST_UNTHR: assert property (
      speed_reg == `TTC_SPEED_WIND_FAST |-> !threaded_reg) else $error("fast");
   AST_ATTEN: assert property (
      audio_atten_reg == (speed_reg == `TTC_SPEED_SEARCH)) else $error("atten");
   AST_REC_THR: assert property (
      |track_recording_reg |-> threaded_reg) else $error("rec unthreaded");
   AST_REC_SPD: assert property (
      |track_recording_reg |-> speed_reg <= `TTC_SPEED_PLAY) else $error("spd");
   AST_XF_PULSE: assert property (
      crossfade_start_reg |=> !crossfade_start_reg) else $error("xf pulse");
   AST_XF_SET: assert property (
      crossfade_ms_reg inside {`TTC_XF0_48, `TTC_XF1_48, `TTC_XF2_48,
      `TTC_XF3_48, `TTC_XF0_441, `TTC_XF1_441, `TTC_XF2_441, `TTC_XF3_441})
      else $error("xf value");
   // Led loads on the same edge as track state, yet only a track recording for two edges is checked
   AST_TRK_LED: assert property (
      (track_recording_reg & $past(track_recording_reg) & ~led_reg[15:8])
      == 8'h00) else $error("track led");
   COV_WIND: cover property (speed_reg == `TTC_SPEED_WIND);
   COV_SEARCH: cover property (audio_atten_reg);
   COV_XF: cover property (crossfade_start_reg);
endmodule // ttc_top_asserts

bind ttc_top ttc_top_asserts u_asserts (.aclk(aclk), .aresetn(aresetn),
   .eject_motor_reg(eject_motor_reg), .threaded_reg(threaded_reg),
   .speed_reg(speed_reg), .audio_atten_reg(audio_atten_reg),
   .track_recording_reg(track_recording_reg),
   .crossfade_ms_reg(crossfade_ms_reg),
   .crossfade_start_reg(crossfade_start_reg), .led_reg(led_reg));
`default_nettype wire

// ---- tb/ttc_mech_model.sv ----
/*
 Tape mechanism model: tracks tape position from commanded speed.
 Assumes speed is in play-speed units per clock cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module ttc_mech_model #(
   parameter logic [15:0] LEN = 16'h0400
) (
   input wire logic aclk,
   input wire logic [5:0] speed_reg,
   input wire logic reverse_reg,
   output logic at_start,
   output logic at_end
);
   // ---------------------------------
   // Position
   // ---------------------------------
   logic [15:0] pos = 16'h0200;
   wire [15:0] stp = {10'h000, speed_reg};
   // Saturate at both ends so the flags stay put
   always @(posedge aclk) begin
      if (reverse_reg)
         pos <= (pos > stp) ? pos - stp : 16'h0000;
      else
         pos <= (pos + stp > LEN) ? LEN : pos + stp;
   end
   assign at_start = (pos == 16'h0000);
   assign at_end = (pos == LEN);
endmodule // ttc_mech_model
`default_nettype wire

// ---- tb/ttc_top_tb_top.sv ----
/*
 Testbench for the transport controller: table of panel presses, then
 hand tests for winding, format loss, eject, crossfade, clock, display.
 Assumes short blink and message counts for simulation.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ttc_defs.vh"
module ttc_top_tb_top;
   // ---------------------------------
   // Signals, design and tasks
   // ---------------------------------
   logic aclk = 0, rstn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd;
   logic [1:0] resp;
   wire awr, wr, bv, arr, rv, sej, emo, thr, rev, att, xfs, at_s;
   wire [1:0] br, rr;
   wire [31:0] rdat;
   wire [5:0] spd, xfm;
   wire [7:0] trk;
   wire [15:0] led;
   int err_count = 0, total_checks = 0, cyc = 0, i;
   logic [5:0] xf48 [4] = '{`TTC_XF0_48, `TTC_XF1_48, `TTC_XF2_48,
      `TTC_XF3_48};
   // Rows: held buttons, pressed button, status, speed
   logic [63:0] rows [15] = '{
      64'h0000_0008_0021_0001, 64'h0000_0008_0021_0001,
      64'h0008_0002_0025_0003, 64'h0000_0008_0021_0001,
      64'h0008_0004_0026_0003, 64'h0000_0020_0020_0000,
      64'h0000_0020_0000_0000, 64'h0000_0002_0003_002c,
      64'h0000_0020_0000_0000, 64'h0000_0100_1000_0000,
      64'h0010_0008_1032_0001, 64'h0000_0008_1021_0001,
      64'h0008_0010_1032_0001, 64'h0000_0002_1023_0028,
      64'h0000_0020_1020_0000};
   always #5 aclk = ~aclk;
   ttc_top #(.BLINK_CYCLES(4), .MSG_CYCLES(8), .MS_CYCLES(4)) dut (
      .aclk(aclk), .aresetn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .slave_eject_reg(sej), .eject_motor_reg(emo), .threaded_reg(thr),
      .speed_reg(spd), .reverse_reg(rev), .audio_atten_reg(att),
      .track_recording_reg(trk), .crossfade_ms_reg(xfm),
      .crossfade_start_reg(xfs), .led_reg(led));
   ttc_mech_model mech (.aclk(aclk), .speed_reg(spd), .reverse_reg(rev),
      .at_start(at_s), .at_end());
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         $display("Error %0t: got %h want %h", $time, g, e);
         err_count++;
      end
   endtask
   // Each channel released only at its own handshake edge
   task axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bry <= 1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 0;
         if (wr) wv <= 0;
      end while (!bv);
      resp = br;
      bry <= 0;
   endtask
   task axi_rd(input logic [7:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1;
      rry <= 1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 0;
      end while (!rv);
      rd = rdat;
      resp = rr;
      rry <= 0;
   endtask
   // A press is a rising button level between two writes
   task press(input logic [15:0] h, input logic [15:0] p);
      axi_wr(8'h00, {16'h0000, h});
      axi_wr(8'h00, {16'h0000, h | p});
      axi_wr(8'h00, 32'h0);
      axi_rd(8'h0c);
   endtask
   task end_sim;
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard, well above the few hundred cycles needed
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end
   initial begin
      repeat (20) @(posedge aclk);
      rstn <= 1;
      axi_rd(8'h10);
      chk(rd, 32'h1);
      axi_rd(8'h08);
      chk(rd[3:0], 4'h0);
      chk(xfm, `TTC_XF0_48);
      $display("Test reset done");
      axi_wr(8'h04, 32'h20);
      for (i = 0; i < 15; i++) begin
         press(rows[i][63:48], rows[i][47:32]);
         chk(rd[15:0] & 16'hf0ff, rows[i][31:16]);
         chk(spd, rows[i][5:0]);
      end
      $display("Test table done");
      press(16'h0, 16'h2);
      chk(rev, 1'b1);
      while (!at_s) @(posedge aclk);
      axi_wr(8'h04, 32'h21);
      axi_rd(8'h10);
      chk(rd[3:0], 4'h1);
      axi_wr(8'h04, 32'h0);
      press(16'h0, 16'h8);
      chk(rd[7], 1'b1);
      press(16'h0, 16'h20);
      axi_wr(8'h04, 32'h20);
      press(16'h10, 16'h8);
      press(16'h0, 16'h1);
      chk(rd[3:0], `TTC_S_REC);
      chk(trk, 8'h01);
      axi_wr(8'h04, 32'h0);
      axi_rd(8'h0c);
      chk(rd[3:0], `TTC_S_STOP);
      axi_wr(8'h04, 32'h20);
      press(16'h0, 16'h1);
      chk(rd[3:0], `TTC_S_EJECT);
      chk(sej, 1'b1);
      axi_wr(8'h04, 32'h420);
      axi_wr(8'h04, 32'h220);
      press(16'h0, 16'h1);
      chk(rd[3:0], `TTC_S_EJECT);
      chk(sej, 1'b0);
      axi_wr(8'h04, 32'h420);
      axi_wr(8'h04, 32'h30);
      axi_wr(8'h04, 32'h28);
      press(16'h0, 16'h8);
      chk(rd[7:0], 8'h67);
      axi_wr(8'h04, 32'h24);
      axi_rd(8'h0c);
      chk(rd[7:0], 8'h21);
      $display("Test transport done");
      for (i = 1; i < 5; i++) begin
         press(16'h80, 16'h10);
         axi_rd(8'h08);
         chk(xfm, xf48[i[1:0]]);
      end
      for (i = 1; i < 5; i++) begin
         press(16'h0, 16'h40);
         axi_rd(8'h08);
         chk(rd[1:0], i[1:0]);
         chk(xfm, i[0] ? `TTC_XF0_441 : `TTC_XF0_48);
      end
      press(16'h80, 16'h800);
      axi_rd(8'h08);
      chk(rd[5], 1'b1);
      axi_wr(8'h04, 32'hf0);
      axi_rd(8'h08);
      chk(rd[4:0], 5'h11);
      axi_rd(8'h20);
      chk(resp, `TTC_RESP_SLVERR);
      axi_wr(8'h14, 32'h1);
      chk(resp, `TTC_RESP_SLVERR);
      $display("Test settings done");
      end_sim();
   end
endmodule // ttc_top_tb_top
`default_nettype wire
